// File: verilog/tll_pkg.sv
/*
 package for the transmitter lane level register bank: offsets, field layout, reset values.
 assumes a 32-bit AXI4-Lite bus and four lanes per lane-select field.
*/
package tll_pkg;
	localparam int LANES = 4;
	localparam int ADDR_W = 4;
	localparam logic [ADDR_W-1:0] OFS_LEVEL_CTRL1 = 4'h0;
	localparam logic [ADDR_W-1:0] OFS_LANE_CTRL = 4'h4;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int STORE_LSB = 13;
	localparam int STORE_W = 19;
	localparam int FS35_FINE_LSB = 13;
	localparam int FS6_LEVEL_LSB = 16;
	localparam int FS6_FINE_LSB = 21;
	localparam int LS1_LEVEL_LSB = 24;
	localparam int LS2_LEVEL_LSB = 28;
	localparam int LEVEL_W = 5;
	localparam int FINE_W = 3;
	localparam int LS_LEVEL_W = 4;
	localparam int LANE_SELECT_FIELD_LSB = 0;
	localparam logic [31:0] STORED_MASK = 32'hFFFF_E000;
	localparam logic [31:0] LEVEL_CTRL1_RESET = 32'h8953_8000;
	localparam logic [3:0] LANE_SELECT_FIELD_RESET = 4'hF;
	localparam logic [31:0] LANE_SELECT_FIELD_MASK = 32'h0000_000F;

	typedef enum logic [1:0] {
		WR_COLLECT = 2'b00,
		WR_COMMIT = 2'b01,
		WR_RESP = 2'b11
	} tll_wr_state_t;

	function automatic logic [31:0] tll_merge(input logic [31:0] oldWord,
		input logic [31:0] newWord, input logic [3:0] strb, input logic [31:0] mask);
		logic [31:0] res;
		res = oldWord;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[b*8 +: 8] = newWord[b*8 +: 8];
			end
		end
		return res & mask;
	endfunction : tll_merge

	function automatic logic [1:0] tll_first_lane(input logic [3:0] sel);
		logic [1:0] idx;
		idx = 2'h0;
		for (int i = LANES - 1; i >= 0; i--) begin
			if (sel[i]) begin
				idx = i[1:0];
			end
		end
		return idx;
	endfunction : tll_first_lane
endpackage : tll_pkg

// File: verilog/tll_lane_store.sv
/*
 per-lane storage of the sticky upper level fields, one word per lane.
 assumes resetn is the fundamental reset; writes arrive one cycle wide.
*/
module tll_lane_store
	import tll_pkg::*;
(
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic wrEn,
	input wire logic [3:0] laneMask,
	input wire logic [3:0] byteEn,
	input wire logic [31:0] wrData,
	output logic [3:0][31:0] laneWord
);
	typedef struct packed {
		logic [3:0][STORE_W-1:0] word;
	} tll_store_t;

	tll_store_t st_reg;
	tll_store_t st_next;
	logic [31:0] merged;

	// only the fundamental reset reaches here, so values survive hot resets
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < LANES; i++) begin
				st_reg.word[i] <= LEVEL_CTRL1_RESET[31:STORE_LSB];
			end
		end else begin
			st_reg <= st_next;
		end
	end

	always_comb begin
		merged = 32'h0000_0000;
		st_next = st_reg;
		for (int i = 0; i < LANES; i++) begin
			merged = tll_merge({st_reg.word[i], 13'h0000}, wrData, byteEn, STORED_MASK);
			if (wrEn && laneMask[i]) begin
				st_next.word[i] = merged[31:STORE_LSB];
			end
		end
	end

	always_comb begin
		for (int i = 0; i < LANES; i++) begin
			laneWord[i] = {st_reg.word[i], 13'h0000};
		end
	end

	lane_unsel_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		(!laneMask[1] || !wrEn) |=> $stable(laneWord[1]))
		else $error("unselected lane changed");
	lane_write_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		(wrEn && laneMask[0] && byteEn == 4'hF) |=> laneWord[0] == ($past(wrData) & STORED_MASK))
		else $error("selected lane not written");
endmodule : tll_lane_store

// File: verilog/tll_regs.sv
/*
 transmitter lane level register bank, upper fields, behind an AXI4-Lite slave.
 assumes a synchronous hot reset input and port mode inputs from the link layer.
*/
// The address map and register access over AXI4-Lite were left to the implementer.
module tll_regs
	import tll_pkg::*;
(
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic hotResetn,
	input wire logic awvalid,
	output logic awready,
	input wire logic [tll_pkg::ADDR_W-1:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic [tll_pkg::ADDR_W-1:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	input wire logic deemphasisSelect,
	input wire logic lowSwingEnable,
	input wire logic linkGen2,
	input wire logic [3:0][tll_pkg::LEVEL_W-1:0] lowerLevelCode,
	input wire logic [3:0][tll_pkg::FINE_W-1:0] lowerFineCode,
	output logic [3:0][tll_pkg::LEVEL_W-1:0] txDriveLevel,
	output logic [3:0][tll_pkg::FINE_W-1:0] txFineDeemph,
	output logic [3:0] txDeemphOn
);
	import tll_pkg::*;

	typedef struct packed {
		tll_wr_state_t wrState;
		logic awHave;
		logic wHave;
		logic [ADDR_W-1:0] wrAddr;
		logic [31:0] wrData;
		logic [3:0] wrStrb;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic [3:0] lane_select_field;
		logic [3:0][LEVEL_W-1:0] level;
		logic [3:0][FINE_W-1:0] fine;
		logic [3:0] deOn;
	} tll_state_t;

	tll_state_t s_reg;
	tll_state_t s_next;
	logic [3:0][31:0] laneWord;
	logic storeWrite;
	logic [31:0] selWord;

	tll_lane_store u_store (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.wrEn(storeWrite),
		.laneMask(s_reg.lane_select_field),
		.byteEn(s_reg.wrStrb),
		.wrData(s_reg.wrData),
		.laneWord(laneWord)
	);

	assign awready = (s_reg.wrState == WR_COLLECT) && !s_reg.awHave;
	assign wready = (s_reg.wrState == WR_COLLECT) && !s_reg.wHave;
	assign bvalid = (s_reg.wrState == WR_RESP);
	assign bresp = s_reg.bresp;
	assign arready = !s_reg.rvalid;
	assign rvalid = s_reg.rvalid;
	assign rdata = s_reg.rdata;
	assign rresp = s_reg.rresp;
	assign txDriveLevel = s_reg.level;
	assign txFineDeemph = s_reg.fine;
	assign txDeemphOn = s_reg.deOn;

	// the stored codes reach the lanes one cycle later, so a write never glitches the driver
	assign storeWrite = (s_reg.wrState == WR_COMMIT) && (s_reg.wrAddr == OFS_LEVEL_CTRL1);
	assign selWord = laneWord[tll_first_lane(s_reg.lane_select_field)];

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			s_reg <= '0;
			s_reg.wrState <= WR_COLLECT;
			s_reg.lane_select_field <= LANE_SELECT_FIELD_RESET;
		end else begin
			s_reg <= s_next;
		end
	end

	always_comb begin
		s_next = s_reg;
		// write channel: address and data in either order, then commit, then answer
		case (s_reg.wrState)
			WR_COLLECT: begin
				if (awvalid && awready) begin
					s_next.awHave = 1'b1;
					s_next.wrAddr = awaddr;
				end
				if (wvalid && wready) begin
					s_next.wHave = 1'b1;
					s_next.wrData = wdata;
					s_next.wrStrb = wstrb;
				end
				if (s_reg.awHave && s_reg.wHave) begin
					s_next.wrState = WR_COMMIT;
				end
			end
			WR_COMMIT: begin
				s_next.wrState = WR_RESP;
				s_next.awHave = 1'b0;
				s_next.wHave = 1'b0;
				s_next.bresp = RESP_OKAY;
				if (s_reg.wrAddr == OFS_LANE_CTRL) begin
					if (s_reg.wrStrb[0]) begin
						s_next.lane_select_field = s_reg.wrData[LANE_SELECT_FIELD_LSB +: 4];
					end
				end else if (s_reg.wrAddr != OFS_LEVEL_CTRL1) begin
					s_next.bresp = RESP_SLVERR;
				end
			end
			WR_RESP: begin
				if (bready) begin
					s_next.wrState = WR_COLLECT;
				end
			end
			default: begin
				s_next.wrState = WR_COLLECT;
			end
		endcase
		// read channel: lowest selected lane answers for the bank
		if (s_reg.rvalid && rready) begin
			s_next.rvalid = 1'b0;
		end
		if (arvalid && arready) begin
			s_next.rvalid = 1'b1;
			s_next.rresp = RESP_OKAY;
			case (araddr)
				OFS_LEVEL_CTRL1: s_next.rdata = selWord;
				OFS_LANE_CTRL: s_next.rdata = {28'h000_0000, s_reg.lane_select_field} & LANE_SELECT_FIELD_MASK;
				default: begin
					s_next.rdata = 32'h0000_0000;
					s_next.rresp = RESP_SLVERR;
				end
			endcase
		end
		// hot reset returns the selection to its reset value 4'hF only; stored codes are left alone
		if (!hotResetn) begin
			s_next.lane_select_field = LANE_SELECT_FIELD_RESET;
		end
		for (int i = 0; i < LANES; i++) begin
			if (lowSwingEnable) begin
				s_next.fine[i] = '0;
				s_next.deOn[i] = 1'b0;
				if (linkGen2) begin
					s_next.level[i] = {1'b0, laneWord[i][LS2_LEVEL_LSB +: LS_LEVEL_W]};
				end else begin
					s_next.level[i] = {1'b0, laneWord[i][LS1_LEVEL_LSB +: LS_LEVEL_W]};
				end
			end else begin
				s_next.deOn[i] = 1'b1;
				if (linkGen2 && deemphasisSelect) begin
					s_next.level[i] = lowerLevelCode[i];
					s_next.fine[i] = laneWord[i][FS35_FINE_LSB +: FINE_W];
				end else if (linkGen2) begin
					s_next.level[i] = laneWord[i][FS6_LEVEL_LSB +: LEVEL_W];
					s_next.fine[i] = laneWord[i][FS6_FINE_LSB +: FINE_W];
				end else begin
					s_next.level[i] = lowerLevelCode[i];
					s_next.fine[i] = lowerFineCode[i];
				end
			end
		end
	end

	// outputs still hold reset values after the release edge, so mode checks skip that edge
	fine_35db_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		(resetn && !lowSwingEnable && linkGen2 && deemphasisSelect)
		|=> txFineDeemph[2] == $past(laneWord[2][FS35_FINE_LSB +: FINE_W]))
		else $error("3.5dB fine code not applied");
	fs35_level_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		(resetn && !lowSwingEnable && linkGen2 && deemphasisSelect)
		|=> txDriveLevel == $past(lowerLevelCode) && txDeemphOn == 4'hF)
		else $error("3.5dB level not taken from lower codes");
	level_6db_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		(resetn && !lowSwingEnable && linkGen2 && !deemphasisSelect)
		|=> txDriveLevel[0] == $past(laneWord[0][FS6_LEVEL_LSB +: LEVEL_W]) && txDeemphOn[0])
		else $error("6dB level not used");
	fine_6db_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		(resetn && !lowSwingEnable && linkGen2 && !deemphasisSelect)
		|=> txFineDeemph[3] == $past(laneWord[3][FS6_FINE_LSB +: FINE_W]))
		else $error("6dB fine code not applied");
	ls_gen1_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		(resetn && lowSwingEnable && !linkGen2)
		|=> txDriveLevel[1] == {1'b0, $past(laneWord[1][LS1_LEVEL_LSB +: LS_LEVEL_W])})
		else $error("low swing gen1 level not used");
	ls_lane3_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		(resetn && lowSwingEnable && !linkGen2)
		|=> txDriveLevel[3] == {1'b0, $past(laneWord[3][LS1_LEVEL_LSB +: LS_LEVEL_W])})
		else $error("low swing gen1 level not used on lane 3");
	ls_gen2_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		(resetn && lowSwingEnable && linkGen2)
		|=> txDriveLevel[0] == {1'b0, $past(laneWord[0][LS2_LEVEL_LSB +: LS_LEVEL_W])})
		else $error("low swing gen2 level not used");
	ls_nodeemph_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		lowSwingEnable |=> txFineDeemph == '0 && txDeemphOn == 4'h0)
		else $error("deemphasis active in low swing");
	gen1_lower_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		(resetn && !lowSwingEnable && !linkGen2)
		|=> txDriveLevel == $past(lowerLevelCode) && txFineDeemph == $past(lowerFineCode))
		else $error("gen1 full swing codes wrong");
	commit_only_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		storeWrite |-> $past(s_reg.awHave) && $past(s_reg.wHave))
		else $error("store written outside a commit");
	empty_select_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		(storeWrite && s_reg.lane_select_field == 4'h0) |=> $stable(laneWord))
		else $error("empty selection changed a lane");
	sticky_store_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		!storeWrite |=> $stable(laneWord))
		else $error("stored codes changed without a write");
	sel_write_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		(s_reg.wrState == WR_COMMIT && s_reg.wrAddr == OFS_LANE_CTRL
		&& s_reg.wrStrb[0] && hotResetn)
		|=> s_reg.lane_select_field == $past(s_reg.wrData[LANE_SELECT_FIELD_LSB +: 4]))
		else $error("lane select not written");
	sel_read_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		(arvalid && arready && araddr == OFS_LANE_CTRL)
		|=> rdata == {28'h000_0000, $past(s_reg.lane_select_field)})
		else $error("lane select read wrong");
	lane_read_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		(arvalid && arready && araddr == OFS_LEVEL_CTRL1 && s_reg.lane_select_field[0])
		|=> rdata == $past(laneWord[0]))
		else $error("lowest selected lane not read");
	unmapped_write_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		(s_reg.wrState == WR_COMMIT && s_reg.wrAddr != OFS_LEVEL_CTRL1
		&& s_reg.wrAddr != OFS_LANE_CTRL)
		|=> bresp == RESP_SLVERR)
		else $error("unmapped write not refused");
	hot_sticky_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		(!hotResetn && !storeWrite) |=> $stable(laneWord) && s_reg.lane_select_field == LANE_SELECT_FIELD_RESET)
		else $error("hot reset disturbed sticky codes");
	write_resp_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		(s_reg.wrState == WR_COMMIT) |=> bvalid[*1] ##0 (s_reg.awHave == 1'b0))
		else $error("write answer missing");
	// bus handshake checks: answers stand until taken and never appear unasked
	bresp_hold_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		(bvalid && !bready) |=> bvalid && $stable(bresp))
		else $error("write answer dropped early");
	rdata_hold_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		(rvalid && !rready) |=> rvalid && $stable(rdata) && $stable(rresp))
		else $error("read answer dropped early");
	stray_bvalid_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		(!bvalid && s_reg.wrState != WR_COMMIT) |=> !bvalid)
		else $error("write answer without a commit");
	stray_rvalid_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		(!rvalid && !(arvalid && arready)) |=> !rvalid)
		else $error("read answer without a request");
	aw_once_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		(awvalid && awready) |=> !awready)
		else $error("write address taken twice");
	w_once_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		(wvalid && wready) |=> !wready)
		else $error("write data taken twice");
	ar_once_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		(arvalid && arready) |=> rvalid && !arready)
		else $error("read address not answered");

	write_cv: cover property (@(posedge ref_clk) disable iff (!resetn)
		storeWrite && s_reg.lane_select_field == 4'h9);
	empty_write_cv: cover property (@(posedge ref_clk) disable iff (!resetn)
		storeWrite && s_reg.lane_select_field == 4'h0);
	slverr_cv: cover property (@(posedge ref_clk) disable iff (!resetn)
		bvalid && bresp == RESP_SLVERR);
	ls_gen2_cv: cover property (@(posedge ref_clk) disable iff (!resetn)
		lowSwingEnable && linkGen2 ##1 !lowSwingEnable);
	hot_reset_cv: cover property (@(posedge ref_clk) disable iff (!resetn)
		!hotResetn ##1 s_reg.lane_select_field == LANE_SELECT_FIELD_RESET);
endmodule : tll_regs

// File: tb/testbench.sv
/*
 self-checking bench for the transmitter lane level register bank, driven over AXI4-Lite.
 assumes tll_pkg offsets and reset words; lower-half codes are fixed per lane.
*/
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import tll_pkg::*;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic hotResetn = 1'b1;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [ADDR_W-1:0] awaddr = 4'h0, araddr = 4'h0;
	logic [31:0] wdata = 32'h0, rdata;
	logic [3:0] wstrb = 4'h0;
	logic [1:0] bresp, rresp;
	logic deemphasisSelect = 1'b0, lowSwingEnable = 1'b0, linkGen2 = 1'b0;
	logic [3:0][LEVEL_W-1:0] lowerLevelCode = {5'h0D, 5'h0C, 5'h0B, 5'h0A};
	logic [3:0][FINE_W-1:0] lowerFineCode = {3'h3, 3'h2, 3'h1, 3'h0};
	logic [3:0][LEVEL_W-1:0] txDriveLevel;
	logic [3:0][FINE_W-1:0] txFineDeemph;
	logic [3:0] txDeemphOn;
	logic [31:0] model [4];
	// mode table {lowSwing, gen2, select3p5}
	logic [2:0] modes [5] = '{3'b011, 3'b010, 3'b000, 3'b100, 3'b110};
	int nMismatch = 0;
	int checks = 0;

	tll_regs dut_u (.ref_clk(ref_clk), .resetn(resetn), .hotResetn(hotResetn),
		.awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
		.wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
		.bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
		.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
		.deemphasisSelect(deemphasisSelect), .lowSwingEnable(lowSwingEnable),
		.linkGen2(linkGen2), .lowerLevelCode(lowerLevelCode), .lowerFineCode(lowerFineCode),
		.txDriveLevel(txDriveLevel), .txFineDeemph(txFineDeemph), .txDeemphOn(txDeemphOn));

	initial begin
		forever #4 ref_clk = ~ref_clk;
	end

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checks, nMismatch);
		if (nMismatch == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : wrap_up

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		checks++;
		if (seen !== exp) begin
			nMismatch++;
			$display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask : chk

	// master holds each channel until its own handshake edge
	task automatic wr_chk(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] expResp);
		int n;
		n = 0;
		@(posedge ref_clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (awvalid && awready === 1'b1) awvalid <= 1'b0;
			if (wvalid && wready === 1'b1) wvalid <= 1'b0;
			n++;
		end while (bvalid !== 1'b1 && n < 200);
		bready <= 1'b0;
		chk({31'h0, bvalid}, 32'h1, "write answer");
		chk({30'h0, bresp}, {30'h0, expResp}, "write response");
	endtask : wr_chk

	task automatic rd_chk(input logic [3:0] a, input logic [31:0] expData,
		input logic [1:0] expResp);
		int n;
		n = 0;
		@(posedge ref_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (arvalid && arready === 1'b1) arvalid <= 1'b0;
			n++;
		end while (rvalid !== 1'b1 && n < 200);
		rready <= 1'b0;
		chk({31'h0, rvalid}, 32'h1, "read answer");
		chk(rdata, expData, "read data");
		chk({30'h0, rresp}, {30'h0, expResp}, "read response");
	endtask : rd_chk

	// walks every port mode and compares each lane against the word model
	task automatic check_modes;
		logic [31:0] w;
		logic [4:0] lvl;
		logic [2:0] fine;
		logic on;
		for (int m = 0; m < 5; m++) begin
			{lowSwingEnable, linkGen2, deemphasisSelect} <= modes[m];
			repeat (3) @(posedge ref_clk);
			for (int i = 0; i < LANES; i++) begin
				w = model[i];
				on = 1'b1;
				lvl = w[20:16];
				fine = w[23:21];
				if (modes[m][2]) begin
					lvl = {1'b0, modes[m][1] ? w[31:28] : w[27:24]};
					fine = 3'h0;
					on = 1'b0;
				end else if (!modes[m][1]) begin
					lvl = lowerLevelCode[i];
					fine = lowerFineCode[i];
				end else if (modes[m][0]) begin
					lvl = lowerLevelCode[i];
					fine = w[15:13];
				end
				chk({27'h0, txDriveLevel[i]}, {27'h0, lvl}, "drive level");
				chk({29'h0, txFineDeemph[i]}, {29'h0, fine}, "fine deemph");
				chk({31'h0, txDeemphOn[i]}, {31'h0, on}, "deemph on");
			end
		end
	endtask : check_modes

	task automatic model_reset;
		for (int i = 0; i < LANES; i++) model[i] = LEVEL_CTRL1_RESET;
	endtask : model_reset

	initial begin
		repeat (5000) @(posedge ref_clk);
		nMismatch++;
		wrap_up();
	end

	initial begin
		model_reset();
		repeat (6) @(posedge ref_clk);
		resetn <= 1'b1;
		rd_chk(OFS_LEVEL_CTRL1, LEVEL_CTRL1_RESET, RESP_OKAY);
		rd_chk(OFS_LANE_CTRL, {28'h0, LANE_SELECT_FIELD_RESET}, RESP_OKAY);
		check_modes();
		// lane 1 only; low bits belong to the lower block and must drop
		wr_chk(OFS_LANE_CTRL, 32'h0000_0002, 4'hF, RESP_OKAY);
		wr_chk(OFS_LEVEL_CTRL1, 32'hA5B7_FFFF, 4'hF, RESP_OKAY);
		model[1] = 32'hA5B7_FFFF & STORED_MASK;
		rd_chk(OFS_LEVEL_CTRL1, model[1], RESP_OKAY);
		// lanes 0 and 3, upper bytes only
		wr_chk(OFS_LANE_CTRL, 32'h0000_0009, 4'hF, RESP_OKAY);
		wr_chk(OFS_LEVEL_CTRL1, 32'h3C6A_0000, 4'hC, RESP_OKAY);
		model[0] = (model[0] & 32'h0000_FFFF) | 32'h3C6A_0000;
		model[3] = model[0];
		rd_chk(OFS_LEVEL_CTRL1, model[0], RESP_OKAY);
		check_modes();
		// empty selection changes no lane
		wr_chk(OFS_LANE_CTRL, 32'h0000_0000, 4'hF, RESP_OKAY);
		wr_chk(OFS_LEVEL_CTRL1, 32'h1234_5678, 4'hF, RESP_OKAY);
		rd_chk(OFS_LEVEL_CTRL1, model[0], RESP_OKAY);
		wr_chk(4'h8, 32'hFFFF_FFFF, 4'hF, RESP_SLVERR);
		rd_chk(4'h8, 32'h0000_0000, RESP_SLVERR);
		// hot reset keeps stored codes, only lane select returns
		hotResetn <= 1'b0;
		@(posedge ref_clk);
		hotResetn <= 1'b1;
		rd_chk(OFS_LANE_CTRL, {28'h0, LANE_SELECT_FIELD_RESET}, RESP_OKAY);
		rd_chk(OFS_LEVEL_CTRL1, model[0], RESP_OKAY);
		check_modes();
		resetn <= 1'b0;
		repeat (2) @(posedge ref_clk);
		resetn <= 1'b1;
		model_reset();
		rd_chk(OFS_LEVEL_CTRL1, LEVEL_CTRL1_RESET, RESP_OKAY);
		check_modes();
		wrap_up();
	end
endmodule : testbench
